// File: verilog/bus_interface.sv
// External multiplexed address/data bus interface with its configuration options.
// Operation
// - Sample option pins in reset, then normal.
// - Byte order selectable and changeable by software.
// - Data cache refill size is one or four.
// - Software lengthens idle on bus direction change.
// - Option extends address hold after latch strobe.
// - Control signals: reads, writes, or both.
// - Address phase first, latched by strobe.
// - Upper address on bus bits 31:4.
// - Active-low byte lane strobes on bits 3:0.
// - Control bit keeps strobes inactive on reads.
// - Write data phase drives buffered store data.
// - Read data enters the on-chip read buffer.
// - Lanes from size, port width, byte order.
// - Valid index bits depend on port width.
// - Index pins name the datum being moved.
// - Singles start at target, step by pieces.
// - Quad reads count from zero by width.
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none

module bus_interface (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 resetn,
	// Register bus
	input  wire logic [3:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	// Core request port
	input  wire logic                 req_valid,
	input  wire bus_if_pkg::bus_req_t req,
	output logic                      req_ready,
	// Read data to the core
	output logic                      rd_valid,
	output logic      [31:0]          rd_data,
	output logic      [1:0]           rd_word,
	// Multiplexed bus and control pins
	input  wire logic [31:0]          ad_in,
	output logic      [31:0]          ad_out,
	output logic                      ad_oe,
	output logic                      ale,
	output logic      [1:0]           ctl_n,
	input  wire logic [1:0]           mem_width,
	input  wire logic                 mem_ack,
	// Datum index pins
	input  wire logic [3:0]           idx_in,
	output logic      [3:0]           idx_out,
	output logic                      idx_oe
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	function automatic logic [1:0] byte_lane(input logic [1:0] off, input logic big);
		byte_lane = big ? ~off : off;
	endfunction : byte_lane

	function automatic logic [3:0] piece_bytes(input logic [1:0] w);
		unique case (w)
			bus_if_pkg::PORT_W16: piece_bytes = 4'h2;
			bus_if_pkg::PORT_W8:  piece_bytes = 4'h1;
			default:              piece_bytes = 4'h4;
		endcase
	endfunction : piece_bytes

	function automatic logic [3:0] lane_mask(input logic [1:0] size, input logic [1:0] off, input logic big);
		unique case (size)
			bus_if_pkg::SIZE_BYTE: lane_mask = 4'h1 << byte_lane(off, big);
			bus_if_pkg::SIZE_HALF: lane_mask = (off[1] ^ big) ? 4'hC : 4'h3;
			default:               lane_mask = 4'hF;
		endcase
	endfunction : lane_mask

	function automatic logic [31:0] piece_out(input logic [31:0] word, input logic [3:0] idx,
			input logic [1:0] w, input logic big);
		logic [1:0] lane;
		lane = byte_lane(idx[1:0], big);
		unique case (w)
			bus_if_pkg::PORT_W16: piece_out = {16'h0000, (idx[1] ^ big) ? word[31:16] : word[15:0]};
			bus_if_pkg::PORT_W8:  piece_out = {24'h000000, word[8*lane +: 8]};
			default:              piece_out = word;
		endcase
	endfunction : piece_out

	function automatic logic [31:0] piece_in(input logic [31:0] word, input logic [31:0] bus,
			input logic [3:0] idx, input logic [1:0] w, input logic big);
		logic [1:0]  lane;
		logic [31:0] res;
		lane = byte_lane(idx[1:0], big);
		res  = word;
		unique case (w)
			bus_if_pkg::PORT_W16: begin
				if (idx[1] ^ big) begin
					res[31:16] = bus[15:0];
				end else begin
					res[15:0] = bus[15:0];
				end
			end
			bus_if_pkg::PORT_W8:  res[8*lane +: 8] = bus[7:0];
			default:              res = bus;
		endcase
		piece_in = res;
	endfunction : piece_in

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	bus_if_pkg::bus_cfg_t   cfg;
	bus_if_pkg::bus_state_t state;
	bus_if_pkg::bus_state_t next_state;
	bus_if_pkg::bus_req_t   cur;
	logic        quad;
	logic [3:0]  idx;
	logic [3:0]  left;
	logic [1:0]  turn_cnt;
	logic [1:0]  port_w;
	logic [1:0]  drain_idx;
	logic [31:0] asm_word;
	logic [31:0] next_word;
	logic [3:0]  strap;
	logic        last_write;
	logic        last_valid;
	logic        avs_ack;
	logic        accept;
	logic        dir_change;
	logic        piece_done;
	logic        word_done;
	logic [3:0]  next_idx;
	logic [3:0]  pieces_m1;
	logic        mem_we;
	logic [1:0]  mem_waddr;

	// ------------------------------------------------------------
	// Reset straps
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			strap <= idx_in;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			idx_oe <= 1'b0;
		end else begin
			idx_oe <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Register bus slave
	// ------------------------------------------------------------
	assign avs_waitrequest = (avs_read | avs_write) & ~avs_ack;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			avs_ack <= 1'b0;
		end else begin
			avs_ack <= (avs_read | avs_write) & ~avs_ack;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cfg <= bus_if_pkg::CTRL_RESET;
		end else if (avs_write && avs_ack && avs_byteenable[0] && avs_address == bus_if_pkg::CTRL_OFS) begin
			cfg <= avs_writedata[7:0];
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && !avs_ack) begin
			avs_readdata <= 32'h00000000;
			if (avs_address == bus_if_pkg::CTRL_OFS) begin
				avs_readdata[7:0] <= cfg;
			end else if (avs_address == bus_if_pkg::STAT_OFS) begin
				avs_readdata[bus_if_pkg::STAT_STATE_POS +: 3] <= state;
				avs_readdata[bus_if_pkg::STAT_DIR_POS]        <= last_write;
				avs_readdata[bus_if_pkg::STAT_IDX_POS +: 4]   <= idx;
				avs_readdata[bus_if_pkg::STAT_STRAP_POS +: 4] <= strap;
				avs_readdata[bus_if_pkg::STAT_WIDTH_POS +: 2] <= port_w;
			end
		end
	end

	// ------------------------------------------------------------
	// Transfer sequencing
	// ------------------------------------------------------------
	assign req_ready  = (state == bus_if_pkg::ST_IDLE);
	assign accept     = req_ready & req_valid;
	assign dir_change = last_valid & (last_write != req.write);
	assign piece_done = (state == bus_if_pkg::ST_DATA) & mem_ack;
	assign next_idx   = idx + piece_bytes(port_w);
	assign word_done  = piece_done & ((left == 4'h0) | (next_idx[1:0] == 2'h0));
	assign next_word  = piece_in(asm_word, ad_in, idx, port_w, cfg.big_endian);

	// Piece count less one, from transfer length and port width, both powers of two.
	always_comb begin
		logic [2:0] len_log;
		logic [2:0] w_log;
		len_log = quad ? 3'h4 : {1'b0, cur.size};
		w_log   = (mem_width == bus_if_pkg::PORT_W8) ? 3'h0 : (mem_width == bus_if_pkg::PORT_W16) ? 3'h1 : 3'h2;
		if (len_log > w_log) begin
			pieces_m1 = 4'((5'h01 << (len_log - w_log)) - 5'h01);
		end else begin
			pieces_m1 = 4'h0;
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			bus_if_pkg::ST_IDLE: begin
				if (accept) begin
					next_state = dir_change ? bus_if_pkg::ST_TURN : bus_if_pkg::ST_ADDR;
				end
			end
			bus_if_pkg::ST_TURN: begin
				if (turn_cnt == 2'h1) begin
					next_state = bus_if_pkg::ST_ADDR;
				end
			end
			bus_if_pkg::ST_ADDR: begin
				next_state = strap[bus_if_pkg::STRAP_EXT_HOLD] ? bus_if_pkg::ST_HOLD : bus_if_pkg::ST_DATA;
			end
			bus_if_pkg::ST_HOLD: next_state = bus_if_pkg::ST_DATA;
			bus_if_pkg::ST_DATA: begin
				if (mem_ack && left == 4'h0) begin
					next_state = cur.write ? bus_if_pkg::ST_IDLE : bus_if_pkg::ST_DRAIN;
				end
			end
			bus_if_pkg::ST_DRAIN: begin
				if (drain_idx == (quad ? bus_if_pkg::QUAD_LAST : 2'h0)) begin
					next_state = bus_if_pkg::ST_IDLE;
				end
			end
			default: next_state = bus_if_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state <= bus_if_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cur        <= '0;
			quad       <= 1'b0;
			last_write <= 1'b0;
			last_valid <= 1'b0;
		end else if (accept) begin
			cur        <= req;
			quad       <= !req.write && (req.kind == bus_if_pkg::KIND_ICACHE
				|| (req.kind == bus_if_pkg::KIND_DCACHE && cfg.dcache_quad));
			last_write <= req.write;
			last_valid <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			turn_cnt <= 2'h0;
		end else if (accept) begin
			turn_cnt <= cfg.slow_turnaround ? bus_if_pkg::TURN_SLOW : bus_if_pkg::TURN_NORMAL;
		end else if (state == bus_if_pkg::ST_TURN) begin
			turn_cnt <= turn_cnt - 2'h1;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			port_w <= bus_if_pkg::PORT_W32;
			left   <= 4'h0;
		end else if (state == bus_if_pkg::ST_ADDR) begin
			port_w <= mem_width;
			left   <= pieces_m1;
		end else if (piece_done) begin
			left <= left - 4'h1;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			idx <= 4'h0;
		end else if (accept) begin
			idx <= req.write || !(req.kind == bus_if_pkg::KIND_ICACHE
				|| (req.kind == bus_if_pkg::KIND_DCACHE && cfg.dcache_quad)) ? req.addr[3:0] : 4'h0;
		end else if (piece_done) begin
			idx <= next_idx;
		end
	end

	assign idx_out = idx;

	// ------------------------------------------------------------
	// Read packing and buffer
	// ------------------------------------------------------------
	assign mem_we    = word_done & ~cur.write;
	assign mem_waddr = quad ? idx[3:2] : 2'h0;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			asm_word <= 32'h00000000;
		end else if (word_done) begin
			asm_word <= 32'h00000000;
		end else if (piece_done) begin
			asm_word <= next_word;
		end
	end

	read_buffer_mem i_read_buffer_mem (
		.mclk  (mclk),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (next_word),
		.raddr (drain_idx),
		.rdata (rd_data)
	);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			drain_idx <= 2'h0;
		end else if (state == bus_if_pkg::ST_DRAIN && next_state == bus_if_pkg::ST_DRAIN) begin
			drain_idx <= drain_idx + 2'h1;
		end else if (state != bus_if_pkg::ST_DRAIN) begin
			drain_idx <= 2'h0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rd_valid <= 1'b0;
			rd_word  <= 2'h0;
		end else begin
			rd_valid <= (state == bus_if_pkg::ST_DRAIN);
			rd_word  <= drain_idx;
		end
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	assign ale   = (state == bus_if_pkg::ST_ADDR);
	assign ad_oe = ale || state == bus_if_pkg::ST_HOLD || (state == bus_if_pkg::ST_DATA && cur.write);

	always_comb begin
		if (state == bus_if_pkg::ST_DATA) begin
			ad_out = piece_out(cur.wdata, idx, port_w, cfg.big_endian);
		end else if (!cur.write && cfg.quiet_read_strobes) begin
			ad_out = {cur.addr[31:4], 4'hF};
		end else begin
			ad_out = {cur.addr[31:4], ~lane_mask(cur.size, cur.addr[1:0], cfg.big_endian)};
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_ctl
		assign ctl_n[g] = !(state == bus_if_pkg::ST_DATA
			&& cfg.ctl_mode[g][cur.write ? bus_if_pkg::MODE_WRITE_BIT : bus_if_pkg::MODE_READ_BIT]);
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	sequence s_addr_phase;
		ale && ad_oe;
	endsequence

	sequence s_hold_phase;
		!ale && ad_oe && $stable(ad_out);
	endsequence

	property p_addr_first;
		accept && !dir_change |=> s_addr_phase ##1 !ale;
	endproperty
	a_addr_first: assert property (p_addr_first) else $error("address phase missing");

	property p_upper_addr;
		ale |-> ad_out[31:4] == cur.addr[31:4];
	endproperty
	a_upper_addr: assert property (p_upper_addr) else $error("upper address wrong");

	property p_quiet_strobes;
		ale && !cur.write && cfg.quiet_read_strobes |-> ad_out[3:0] == 4'hF;
	endproperty
	a_quiet_strobes: assert property (p_quiet_strobes) else $error("read strobes active");

	property p_ext_hold;
		s_addr_phase ##0 strap[bus_if_pkg::STRAP_EXT_HOLD] |=> s_hold_phase;
	endproperty
	a_ext_hold: assert property (p_ext_hold) else $error("address hold not extended");

	property p_slow_turn;
		accept && dir_change && cfg.slow_turnaround |=> !ale [*3] ##1 ale;
	endproperty
	a_slow_turn: assert property (p_slow_turn) else $error("turnaround length wrong");

	property p_quad_from_zero;
		ale && quad |-> idx_out == 4'h0;
	endproperty
	a_quad_from_zero: assert property (p_quad_from_zero) else $error("quad index not zero");

	property p_index_step;
		piece_done && left != 4'h0 |=> idx_out == 4'($past(idx_out) + piece_bytes(port_w));
	endproperty
	a_index_step: assert property (p_index_step) else $error("index did not step");

	property p_write_drive;
		state == bus_if_pkg::ST_DATA && cur.write |-> ad_oe && ad_out == piece_out(cur.wdata, idx, port_w, cfg.big_endian);
	endproperty
	a_write_drive: assert property (p_write_drive) else $error("store data not driven");

	property p_ctl_mode;
		!ctl_n[0] |-> state == bus_if_pkg::ST_DATA && cfg.ctl_mode[0][cur.write ? 1 : 0];
	endproperty
	a_ctl_mode: assert property (p_ctl_mode) else $error("control signal mode wrong");

	property p_read_buffered;
		piece_done && left == 4'h0 && !cur.write |=> state == bus_if_pkg::ST_DRAIN ##1 rd_valid;
	endproperty
	a_read_buffered: assert property (p_read_buffered) else $error("read data not delivered");

	property p_pins_revert;
		idx_oe |=> idx_oe;
	endproperty
	a_pins_revert: assert property (p_pins_revert) else $error("index pins released");

endmodule : bus_interface

`default_nettype wire

// File: verilog/bus_if_pkg.sv
// Shared constants, codes and carrier types of the external bus interface.
`default_nettype none
package bus_if_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0]  CTRL_OFS   = 4'h0;
	localparam logic [3:0]  STAT_OFS   = 4'h4;
	localparam logic [7:0]  CTRL_RESET = 8'hF0;

	// Status word field positions.
	localparam int STAT_STATE_POS = 0;
	localparam int STAT_DIR_POS   = 3;
	localparam int STAT_IDX_POS   = 4;
	localparam int STAT_STRAP_POS = 8;
	localparam int STAT_WIDTH_POS = 12;

	// ------------------------------------------------------------
	// Reset strap bits on the datum index pins
	// ------------------------------------------------------------
	localparam int STRAP_BOOT_BYTE = 0;
	localparam int STRAP_RESERVED  = 1;
	localparam int STRAP_EXT_HOLD  = 2;

	// ------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------
	localparam logic [1:0] PORT_W32 = 2'h0;
	localparam logic [1:0] PORT_W16 = 2'h1;
	localparam logic [1:0] PORT_W8  = 2'h2;

	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	localparam logic [1:0] KIND_UNCACHED = 2'h0;
	localparam logic [1:0] KIND_ICACHE   = 2'h1;
	localparam logic [1:0] KIND_DCACHE   = 2'h2;

	// Control signal modes: bit 0 reads, bit 1 writes.
	localparam int MODE_READ_BIT  = 0;
	localparam int MODE_WRITE_BIT = 1;

	// ------------------------------------------------------------
	// Timing counts in mclk cycles, and the last word index of a quad drain
	// ------------------------------------------------------------
	localparam logic [1:0] TURN_NORMAL = 2'h1;
	localparam logic [1:0] TURN_SLOW   = 2'h3;
	localparam logic [1:0] QUAD_LAST   = 2'h3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_TURN  = 3'h4,
		ST_ADDR  = 3'h1,
		ST_HOLD  = 3'h3,
		ST_DATA  = 3'h2,
		ST_DRAIN = 3'h6
	} bus_state_t;

	typedef struct packed {
		logic [1:0][1:0] ctl_mode;
		logic            quiet_read_strobes;
		logic            slow_turnaround;
		logic            dcache_quad;
		logic            big_endian;
	} bus_cfg_t;

	typedef struct packed {
		logic        write;
		logic [1:0]  kind;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} bus_req_t;

endpackage : bus_if_pkg

`default_nettype wire

// File: verilog/read_buffer_mem.sv
// Four-word on-chip read buffer with a registered read port.
`timescale 1ns/10ps
`default_nettype none

module read_buffer_mem (
	// Clock
	input  wire logic        mclk,
	// Write port
	input  wire logic        we,
	input  wire logic [1:0]  waddr,
	input  wire logic [31:0] wdata,
	// Read port
	input  wire logic [1:0]  raddr,
	output logic      [31:0] rdata
);

	logic [31:0] mem [4];

	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge mclk) begin
		rdata <= mem[raddr];
	end

endmodule : read_buffer_mem

`default_nettype wire

// File: sim/mem_model.sv
// Behavioural memory system that answers the multiplexed bus interface.
`timescale 1ns/10ps
`default_nettype none

module mem_model #(
	parameter logic [3:0] STRAP = 4'h6
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// Bus pins
	input  wire logic [31:0] ad_out,
	input  wire logic        ad_oe,
	input  wire logic        ale,
	input  wire logic [3:0]  idx_out,
	input  wire logic        idx_oe,
	output logic      [31:0] ad_in,
	output logic      [3:0]  idx_in,
	output logic      [1:0]  mem_width,
	output logic             mem_ack,
	// Bench controls
	input  wire logic [1:0]  width,
	input  wire logic [3:0]  np,
	input  wire logic        lat
);
	int left;
	int wt;

	// Straps show only in reset; later the device drives the index pins.
	assign idx_in    = !resetn ? STRAP : (idx_oe ? idx_out : ~idx_out);
	assign mem_width = width;
	// Read data follow the index, so each piece carries its own pattern.
	assign ad_in     = ad_oe ? ~ad_out : {8{idx_out ^ 4'h5}};

	// Strobes are never decoded, since narrow ports ignore them.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			left = 0;
			wt = 0;
			mem_ack <= 1'b0;
		end else begin
			if (ale) begin
				left = int'(np);
				wt = int'(STRAP[2]) + int'(lat);
			end else if (mem_ack) begin
				left = left - 1;
				wt = int'(lat);
			end else if (wt != 0) begin
				wt = wt - 1;
			end
			mem_ack <= (left != 0) && (wt == 0);
		end
	end
endmodule : mem_model
`default_nettype wire

// File: sim/bus_interface_bench.sv
// Self-checking bench of the external bus interface.
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module bus_interface_bench;
	logic                 mclk, resetn, avs_read, avs_write, avs_waitrequest, req_valid, req_ready;
	logic [3:0]           avs_address, avs_byteenable, idx_in, idx_out, np;
	logic [31:0]          avs_writedata, avs_readdata, rd_data, ad_in, ad_out, rdv, a_last;
	logic [1:0]           rd_word, ctl_n, mem_width, width;
	logic                 ad_oe, ale, mem_ack, idx_oe, lat, held, rd_valid;
	bus_if_pkg::bus_req_t req;
	int                   num_errors, tests_run, cycles, gap;
	logic [3:0]           i_q[$];
	logic [31:0]          w_q[$], r_q[$];
	logic [1:0]           c_q[$], k_q[$];

	bus_interface i_bus_interface (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.rd_word(rd_word), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .ale(ale), .ctl_n(ctl_n),
		.mem_width(mem_width), .mem_ack(mem_ack), .idx_in(idx_in), .idx_out(idx_out), .idx_oe(idx_oe));

	mem_model i_mem_model (.mclk(mclk), .resetn(resetn), .ad_out(ad_out), .ad_oe(ad_oe), .ale(ale),
		.idx_out(idx_out), .idx_oe(idx_oe), .ad_in(ad_in), .idx_in(idx_in), .mem_width(mem_width),
		.mem_ack(mem_ack), .width(width), .np(np), .lat(lat));

	// ------------------------------------------------------------
	// Clock, timeout and verdict
	// ------------------------------------------------------------
	always #20 mclk = ~mclk;

	task print_verdict;
		if (num_errors == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			print_verdict();
		end
	end

	// ------------------------------------------------------------
	// Pin monitor, sampled where values are settled
	// ------------------------------------------------------------
	always @(negedge mclk) begin
		if (resetn) begin
			if (held) `CHK({ale, ad_oe, ad_out}, {2'h1, a_last})
			if (ale) a_last = ad_out;
			if (mem_ack) begin
				i_q.push_back(idx_out);
				w_q.push_back(ad_out);
				c_q.push_back(ctl_n);
			end
			if (rd_valid) begin
				r_q.push_back(rd_data);
				k_q.push_back(rd_word);
			end
			held = ale;
		end
	end

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task av(input logic w, input logic [3:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		while (!done) begin
			@(posedge mclk);
			done = (avs_waitrequest === 1'b0);
		end
		rdv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask : av

	task xfer(input logic w, input logic [1:0] k, input logic [1:0] s, input logic [31:0] a,
		input logic [31:0] d, input logic [3:0] n);
		logic taken;
		taken = 1'b0;
		gap = 0;
		i_q.delete();
		w_q.delete();
		c_q.delete();
		r_q.delete();
		k_q.delete();
		np <= n;
		req_valid <= 1'b1;
		req <= '{write: w, kind: k, size: s, addr: a, wdata: d};
		while (!taken) begin
			@(posedge mclk);
			taken = (req_ready === 1'b1);
		end
		req_valid <= 1'b0;
		do begin
			@(negedge mclk);
			gap++;
		end while (ale !== 1'b1);
		do @(negedge mclk); while (req_ready !== 1'b1);
		repeat (4) @(negedge mclk);
		@(posedge mclk);
	endtask : xfer

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		mclk = 0;
		resetn = 0;
		{avs_read, avs_write, req_valid, lat, held} = '0;
		{avs_address, avs_writedata, np} = '0;
		avs_byteenable = 4'hF;
		req = '0;
		width = bus_if_pkg::PORT_W32;
		repeat (6) @(posedge mclk);
		`CHK(idx_oe, 1'b0)
		resetn <= 1'b1;
		repeat (2) @(posedge mclk);
		`CHK(idx_oe, 1'b1)
		av(0, bus_if_pkg::STAT_OFS, 0);
		`CHK(rdv[11:8], 4'h6)
		av(0, bus_if_pkg::CTRL_OFS, 0);
		`CHK(rdv, {24'h0, bus_if_pkg::CTRL_RESET})
		av(0, 4'h8, 0);
		`CHK(rdv, 32'h00000000)
		av(1, bus_if_pkg::CTRL_OFS, 32'h00000060);
		xfer(1, bus_if_pkg::KIND_UNCACHED, bus_if_pkg::SIZE_WORD, 32'h1234567C, 32'hA5C39E71, 4'h1);
		`CHK(a_last, 32'h12345670)
		`CHK(w_q[0], 32'hA5C39E71)
		`CHK(c_q[0], 2'h2)
		`CHK(i_q[0], 4'hC)
		xfer(0, bus_if_pkg::KIND_UNCACHED, bus_if_pkg::SIZE_WORD, 32'h00002004, 32'h0, 4'h1);
		`CHK(gap, 2)
		`CHK(r_q[0], 32'h11111111)
		`CHK(c_q[0], 2'h1)
		`CHK(a_last[3:0], 4'h0)
		av(1, bus_if_pkg::CTRL_OFS, 32'h000000FC);
		xfer(1, bus_if_pkg::KIND_UNCACHED, bus_if_pkg::SIZE_WORD, 32'h00003000, 32'h00000001, 4'h1);
		`CHK(gap, 4)
		`CHK(c_q[0], 2'h0)
		xfer(0, bus_if_pkg::KIND_UNCACHED, bus_if_pkg::SIZE_WORD, 32'h00003008, 32'h0, 4'h1);
		`CHK(gap, 4)
		`CHK(a_last[3:0], 4'hF)
		`CHK(r_q[0], 32'hDDDDDDDD)
		av(1, bus_if_pkg::CTRL_OFS, 32'h000000F0);
		lat <= 1'b1;
		xfer(0, bus_if_pkg::KIND_ICACHE, bus_if_pkg::SIZE_WORD, 32'h00000048, 32'h0, 4'h4);
		lat <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			`CHK(i_q[k], 4'(k * 4))
			`CHK(r_q[k], {8{4'(k * 4) ^ 4'h5}})
			`CHK(k_q[k], 2'(k))
		end
		for (int q = 0; q < 2; q++) begin
			av(1, bus_if_pkg::CTRL_OFS, 32'h000000F0 | 32'(q * 2));
			xfer(0, bus_if_pkg::KIND_DCACHE, bus_if_pkg::SIZE_WORD, 32'h00000010, 32'h0, 4'(q * 3 + 1));
			`CHK(r_q.size(), q * 3 + 1)
		end
		width <= bus_if_pkg::PORT_W8;
		xfer(1, bus_if_pkg::KIND_UNCACHED, bus_if_pkg::SIZE_WORD, 32'h00000024, 32'h44332211, 4'h4);
		for (int k = 0; k < 4; k++) begin
			`CHK(i_q[k], 4'(4 + k))
			`CHK(w_q[k][7:0], 8'(8'h11 * (k + 1)))
		end
		av(0, bus_if_pkg::STAT_OFS, 0);
		`CHK(rdv, 32'h00002688)
		width <= bus_if_pkg::PORT_W16;
		xfer(0, bus_if_pkg::KIND_ICACHE, bus_if_pkg::SIZE_WORD, 32'h00000000, 32'h0, 4'h8);
		for (int k = 0; k < 8; k++) `CHK(i_q[k], 4'(2 * k))
		`CHK(r_q.size(), 4)
		`CHK(r_q[0], 32'h77775555)
		width <= bus_if_pkg::PORT_W32;
		for (int b = 0; b < 2; b++) begin
			av(1, bus_if_pkg::CTRL_OFS, 32'h000000F0 | 32'(b));
			xfer(1, bus_if_pkg::KIND_UNCACHED, bus_if_pkg::SIZE_BYTE, 32'h00000051, 32'h0000AB00 << (8 * b), 4'h1);
			`CHK(a_last[3:0], b ? 4'hB : 4'hD)
			`CHK(w_q[0], 32'h0000AB00 << (8 * b))
		end
		xfer(1, bus_if_pkg::KIND_UNCACHED, bus_if_pkg::SIZE_HALF, 32'h00000062, 32'h00001234, 4'h1);
		`CHK(a_last[3:0], 4'hC)
		`CHK(w_q[0], 32'h00001234)
		print_verdict();
	end
endmodule : bus_interface_bench
`default_nettype wire
